// ### iwd_host.sv
// host model making byte writes to the watchdog port
`timescale 1ns/1ps
module iwd_host (
    // clock and write port
    input  wire logic i_ref_clk,
    output logic [9:0] o_io_addr = 10'h000,
    output logic [7:0] o_io_data = 8'h00,
    output logic       o_io_wr   = 1'b0
);
    // set at falling edge, held over one rising edge
    task automatic io_write(input logic [9:0] a, input logic [7:0] d);
        @(negedge i_ref_clk);
        o_io_addr = a;
        o_io_data = d;
        o_io_wr   = 1'b1;
        @(negedge i_ref_clk);
        o_io_wr   = 1'b0;
        o_io_addr = ~a; // idle bus shows no stale value
        o_io_data = ~d;
    endtask
endmodule

// ### iwd_pkg.sv
// constants, state codes and factor layout for the io-mapped watchdog timer
package iwd_pkg;

    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int unsigned CLK_HZ          = 25_000_000;  // board reference clock
    localparam int unsigned HALF_UNIT_MS    = 3000;        // half of the ~6 s factor unit
    localparam int unsigned HALF_UNIT_CYC   = HALF_UNIT_MS * (CLK_HZ / 1000);
    localparam int unsigned RST_PULSE_US    = 4;           // system reset pulse width
    localparam int unsigned RST_PULSE_CYC   = RST_PULSE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned LED_HALF_MS     = 250;         // led on/off time while counting
    localparam int unsigned LED_HALF_CYC    = LED_HALF_MS * (CLK_HZ / 1000);

    // ****************************************************************
    // io decode
    // ****************************************************************
    localparam int          IO_ADDR_W       = 10;          // isa i/o decode width
    localparam logic [9:0]  FACTOR_REG_OFF     = 10'h214;  // factor register, switch off
    localparam logic [9:0]  FACTOR_REG_OFF_ALT = 10'h294;  // factor register, switch on

    // ****************************************************************
    // factor byte layout
    // ****************************************************************
    localparam logic [7:0]  FACTOR_OFF      = 8'h00;       // disable value
    localparam int          FACTOR_IRQ_BIT  = 6;           // 1 = interrupt, 0 = reset
    localparam int          FACTOR_CODE_LSB = 0;           // period code field
    localparam int          FACTOR_CODE_W   = 3;
    localparam int          HALF_CNT_W      = 4;           // counts up to 14 halves

    // ****************************************************************
    // control states, one-hot
    // ****************************************************************
    typedef enum logic [3:0] {
        IWD_OFF   = 4'b0001,   // disabled
        IWD_RUN   = 4'b0010,   // counting toward time-out
        IWD_PULSE = 4'b0100,   // driving system reset pulse
        IWD_IRQ   = 4'b1000    // interrupt raised, waiting for a write
    } iwd_state_t;

endpackage

// ### iwd_watchdog.sv
// io-mapped watchdog timer with reset or interrupt time-out action
`timescale 1ns/1ps

// Functional notes
// - disabled after reset until nonzero factor written
// - led blinks while counting, steady when off
// - byte write of factor enables with period
// - every nonzero write outside the reset pulse clears elapsed count and restarts
// - writing 00h disables, no further time-out action
// - time-out gives reset pulse or irq15
// - unit about 6 s, half to 7 units
// - c0h..c7h give 3..42 s, interrupt mode
// - 84h is 24 s reset, c4h 24 s irq
// - new factor applies at once
// - host enables before unmasking the interrupt
// - decode 214h-215h or 294h-295h by switch
module iwd_watchdog
    import iwd_pkg::*;
#(
    parameter int unsigned HALF_UNIT_CYCLES = HALF_UNIT_CYC,  // one half factor unit
    parameter int unsigned LED_CYCLES       = LED_HALF_CYC,   // led toggle interval
    parameter int unsigned PULSE_CYCLES     = RST_PULSE_CYC   // reset pulse width
) (
    // clock and reset
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_rst,
    // host i/o write port
    input  wire logic [IO_ADDR_W-1:0] i_io_addr,
    input  wire logic [7:0]           i_io_data,
    input  wire logic                 i_io_wr,
    // board switch
    input  wire logic                 i_io_base_select_switch,
    // time-out actions and indicator
    output logic                      o_sys_reset,
    output logic                      o_irq15,
    output logic                      o_led
);

    // ****************************************************************
    // local widths
    // ****************************************************************
    localparam int PRE_W = $clog2(HALF_UNIT_CYCLES + 1);  // prescaler width
    localparam int LED_W = $clog2(LED_CYCLES + 1);        // led divider width
    localparam int PUL_W = $clog2(PULSE_CYCLES + 1);      // pulse counter width

    // ****************************************************************
    // state
    // ****************************************************************
    iwd_state_t              state;       // control state
    iwd_state_t              next_state;
    logic                    irq_mode;    // action selected by factor
    logic                    next_irq_mode;
    logic [FACTOR_CODE_W-1:0] code;       // period code
    logic [FACTOR_CODE_W-1:0] next_code;
    logic [PRE_W-1:0]        pre;         // prescaler toward one tick
    logic [PRE_W-1:0]        next_pre;
    logic [HALF_CNT_W-1:0]   halves;      // elapsed half units
    logic [HALF_CNT_W-1:0]   next_halves;
    logic [PUL_W-1:0]        pulse;       // reset pulse cycles done
    logic [PUL_W-1:0]        next_pulse;
    logic [LED_W-1:0]        led_div;     // led divider
    logic [LED_W-1:0]        next_led_div;
    logic                    led;         // led level
    logic                    next_led;
    logic                    sys_reset;   // reset output register
    logic                    next_sys_reset;
    logic                    irq;         // interrupt output register
    logic                    next_irq;

    // ****************************************************************
    // decode and derived terms
    // ****************************************************************
    logic                    hit;         // write to our port pair
    logic                    tick;        // prescaled half-unit tick
    logic [HALF_CNT_W-1:0]   limit;       // halves that make the period

    // port pair chosen by switch, both ports of the pair map the register
    always_comb begin
        if (i_io_base_select_switch) begin
            hit = i_io_wr && (i_io_addr[9:1] == FACTOR_REG_OFF_ALT[9:1]);
        end else begin
            hit = i_io_wr && (i_io_addr[9:1] == FACTOR_REG_OFF[9:1]);
        end
    end

    // fixed tick from board clock
    assign tick = (pre == PRE_W'(HALF_UNIT_CYCLES - 1));

    // code 0 is a half unit, otherwise code whole units of two halves
    always_comb begin
        if (code == '0) begin
            limit = HALF_CNT_W'(1);
        end else begin
            limit = HALF_CNT_W'({code, 1'b0});
        end
    end

    // ****************************************************************
    // control next state
    // ****************************************************************
    always_comb begin
        next_state     = state;
        next_irq_mode  = irq_mode;
        next_code      = code;
        next_pre       = pre;
        next_halves    = halves;
        next_pulse     = pulse;
        next_sys_reset = 1'b0;
        next_irq       = irq;
        if (hit && state != IWD_PULSE) begin
            // any write restarts the count from zero
            next_pre    = '0;
            next_halves = '0;
            // enabling never raises the interrupt by itself
            next_irq    = 1'b0;
            if (i_io_data == FACTOR_OFF) begin
                next_state = IWD_OFF;
            end else begin
                // new factor takes effect now
                next_state    = IWD_RUN;
                next_irq_mode = i_io_data[FACTOR_IRQ_BIT];
                next_code     = i_io_data[FACTOR_CODE_LSB +: FACTOR_CODE_W];
            end
        end else begin
            unique case (state)
                IWD_OFF: begin
                    next_irq = 1'b0;
                end
                IWD_RUN: begin
                    if (tick) begin
                        next_pre = '0;
                        if (halves + HALF_CNT_W'(1) >= limit) begin
                            next_halves = '0;
                            if (irq_mode) begin
                                next_state = IWD_IRQ;
                                next_irq   = 1'b1;
                            end else begin
                                next_state     = IWD_PULSE;
                                next_pulse     = '0;
                                next_sys_reset = 1'b1;
                            end
                        end else begin
                            next_halves = halves + HALF_CNT_W'(1);
                        end
                    end else begin
                        next_pre = pre + PRE_W'(1);
                    end
                end
                IWD_PULSE: begin
                    // fixed width pulse, then back to disabled
                    if (pulse == PUL_W'(PULSE_CYCLES - 1)) begin
                        next_state = IWD_OFF;
                    end else begin
                        next_pulse     = pulse + PUL_W'(1);
                        next_sys_reset = 1'b1;
                    end
                end
                IWD_IRQ: begin
                    next_irq = 1'b1;
                end
            endcase
        end
    end

    // control registers
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state     <= IWD_OFF;
            irq_mode  <= 1'b0;
            code      <= '0;
            pre       <= '0;
            halves    <= '0;
            pulse     <= '0;
            sys_reset <= 1'b0;
            irq       <= 1'b0;
        end else begin
            state     <= next_state;
            irq_mode  <= next_irq_mode;
            code      <= next_code;
            pre       <= next_pre;
            halves    <= next_halves;
            pulse     <= next_pulse;
            sys_reset <= next_sys_reset;
            irq       <= next_irq;
        end
    end

    // ****************************************************************
    // indicator led
    // ****************************************************************
    always_comb begin
        next_led_div = '0;
        next_led     = 1'b0;
        if (state == IWD_RUN) begin
            // blink while counting
            if (led_div == LED_W'(LED_CYCLES - 1)) begin
                next_led = ~led;
            end else begin
                next_led_div = led_div + LED_W'(1);
                next_led     = led;
            end
        end
    end

    // led registers, steady off when not counting
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            led_div <= '0;
            led     <= 1'b0;
        end else begin
            led_div <= next_led_div;
            led     <= next_led;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign o_sys_reset = sys_reset;
    assign o_irq15     = irq;
    assign o_led       = led;

endmodule

// ### iwd_watchdog_chk.sv
// concurrent checks on the watchdog ports
`timescale 1ns/1ps
module iwd_watchdog_chk
    import iwd_pkg::*;
#(parameter int unsigned HALF_UNIT_CYCLES = 10, parameter int unsigned PULSE_CYCLES = 4) (
    // clock, reset, host port
    input wire logic       i_ref_clk,
    input wire logic       i_rst,
    input wire logic [9:0] i_io_addr,
    input wire logic [7:0] i_io_data,
    input wire logic       i_io_wr,
    input wire logic       i_io_base_select_switch,
    // watched outputs
    input wire logic       o_sys_reset,
    input wire logic       o_irq15,
    input wire logic       o_led
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    logic        hit, act, run, next_run; // taken write, action, counting
    logic [7:0]  fac, next_fac;           // last factor taken
    logic [31:0] cnt, next_cnt, lim;      // cycles since write, limit
    logic [31:0] pcnt, next_pcnt;         // cycles the reset pulse has stood
    assign act = o_sys_reset | o_irq15;
    assign hit = i_io_wr & !o_sys_reset & (i_io_addr[9:1] ==
        (i_io_base_select_switch ? FACTOR_REG_OFF_ALT[9:1] : FACTOR_REG_OFF[9:1]));
    // ****************************************************************
    // reference count of the time-out
    // ****************************************************************
    always_comb begin
        next_run = hit ? (i_io_data != FACTOR_OFF) : (run & !act);
        next_fac = hit ? i_io_data : fac;
        next_cnt = hit ? 32'h0000_0001 : cnt + 32'h0000_0001;
        next_pcnt = o_sys_reset ? pcnt + 32'h0000_0001 : 32'h0000_0000;
        lim = 32'(HALF_UNIT_CYCLES)
            * ((fac[2:0] == 3'h0) ? 32'h0000_0001 : {28'h000_0000, fac[2:0], 1'b0});
    end
    always_ff @(posedge i_ref_clk) begin
        run  <= i_rst ? 1'b0 : next_run;
        fac  <= i_rst ? 8'h00 : next_fac;
        cnt  <= i_rst ? 32'h0000_0000 : next_cnt;
        pcnt <= i_rst ? 32'h0000_0000 : next_pcnt;
    end
    a_pulse_width: assert property ((o_sys_reset | $fell(o_sys_reset)) |->
        (o_sys_reset ? (pcnt < 32'(PULSE_CYCLES)) : (pcnt == 32'(PULSE_CYCLES))))
        else $error("reset pulse width wrong");
    a_act_time: assert property ($rose(act) |-> run && cnt + 32'h0000_0001 >= lim
        && cnt <= lim + 32'h0000_0003)
        else $error("time-out at wrong moment");
    a_act_kind: assert property ($rose(act) |-> o_irq15 == fac[FACTOR_IRQ_BIT])
        else $error("time-out action wrong");
    a_time_bound: assert property (run && !act |-> cnt <= lim + 32'h0000_0003)
        else $error("time-out missing");
    a_write_quiet: assert property (hit |-> ##2 !act [*7])
        else $error("action soon after write");
    a_irq_hold: assert property (o_irq15 && !hit |=> o_irq15)
        else $error("interrupt dropped");
    a_led_idle: assert property (act ##1 act |-> !o_led)
        else $error("led lit while not counting");
    a_led_blink: assert property (not (run && !act && $stable(o_led)) [*7])
        else $error("led not blinking");
endmodule
bind iwd_watchdog iwd_watchdog_chk #(
    .HALF_UNIT_CYCLES(HALF_UNIT_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)) u_chk (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_io_addr(i_io_addr), .i_io_data(i_io_data),
    .i_io_wr(i_io_wr), .i_io_base_select_switch(i_io_base_select_switch),
    .o_sys_reset(o_sys_reset), .o_irq15(o_irq15), .o_led(o_led));

// ### tb_iwd_watchdog.sv
// self-checking bench for the watchdog timer
`timescale 1ns/1ps
module tb_iwd_watchdog
    import iwd_pkg::*;
;
    localparam int HALF = 10;  // shortened half unit
    logic       clk = 1'b0;    // 25 mhz clock
    logic       rst = 1'b1;    // reset
    logic       sw  = 1'b0;    // base switch
    logic [9:0] addr;
    logic [7:0] data, f;
    logic       wr, sys_rst, irq, led;
    int         miscompares = 0;
    int         checks = 0;
    int         n, t, lim;
    iwd_host u_iwd_host (.i_ref_clk(clk), .o_io_addr(addr), .o_io_data(data), .o_io_wr(wr));
    iwd_watchdog #(.HALF_UNIT_CYCLES(HALF), .LED_CYCLES(3), .PULSE_CYCLES(4)) u_iwd_watchdog (
        .i_ref_clk(clk), .i_rst(rst), .i_io_addr(addr), .i_io_data(data), .i_io_wr(wr),
        .i_io_base_select_switch(sw), .o_sys_reset(sys_rst), .o_irq15(irq), .o_led(led));
    task automatic ok(input logic c, input string msg);
        checks++;
        if (c !== 1'b1) begin
            miscompares++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    // falling edges until an action shows or max runs out
    task automatic wait_act(input int max, output int k);
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (!(sys_rst | irq) && k < max);
    endtask
    task automatic print_verdict;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial forever #20 clk = ~clk;
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        print_verdict();
    end
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        wait_act(50, n);
        ok(n == 50 && !(sys_rst | irq | led), "not idle after reset");
        for (int m = 0; m < 2; m++) begin
            for (int c = 0; c < 8; c++) begin
                f = (m == 1) ? (8'hc0 | 8'(c)) : (8'h80 | 8'(c));
                lim = ((c == 0) ? 1 : 2 * c) * HALF;
                u_iwd_host.io_write(FACTOR_REG_OFF, f);
                wait_act(400, n);
                ok(n >= lim - 1 && n <= lim + 3, "period");
                ok(irq === (m == 1) && sys_rst === (m == 0), "action");
                if (m == 1) begin
                    repeat (5) @(negedge clk);
                    ok(irq === 1'b1, "irq not held");
                    u_iwd_host.io_write(FACTOR_REG_OFF, FACTOR_OFF);
                    @(negedge clk);
                    ok(irq === 1'b0 && led === 1'b0, "irq not cleared");
                end else begin
                    // a trigger inside the pulse is ignored, the pulse runs on
                    if (c == 1) u_iwd_host.io_write(FACTOR_REG_OFF, 8'h81);
                    for (t = 0; sys_rst === 1'b1 && t < 20; t++) @(negedge clk);
                    ok(t == ((c == 1) ? 2 : 4), "pulse width");
                end
                wait_act(100, n);
                ok(n == 100 && !(sys_rst | irq), "action while off");
            end
        end
        u_iwd_host.io_write(FACTOR_REG_OFF, 8'h84);
        repeat (3) begin
            t = 0;
            repeat (60) begin
                f[0] = led;
                @(negedge clk);
                t += int'(led !== f[0]);
            end
            ok(t >= 17 && t <= 21, "blink rate");
            u_iwd_host.io_write(FACTOR_REG_OFF, 8'h84);
        end
        wait_act(400, n);
        ok(n >= 79 && n <= 83, "retrigger");
        repeat (8) @(negedge clk);
        u_iwd_host.io_write(FACTOR_REG_OFF, 8'h87);
        repeat (20) @(negedge clk);
        u_iwd_host.io_write(FACTOR_REG_OFF, 8'hc1);
        wait_act(400, n);
        ok(n >= 19 && n <= 23 && irq === 1'b1, "new period");
        u_iwd_host.io_write(FACTOR_REG_OFF + 10'h001, 8'h84);
        repeat (30) @(negedge clk);
        sw = 1'b1;
        // switch on: the old pair and a port beside the new pair are ignored
        u_iwd_host.io_write(FACTOR_REG_OFF, FACTOR_OFF);
        u_iwd_host.io_write(FACTOR_REG_OFF_ALT + 10'h002, FACTOR_OFF);
        wait_act(400, n);
        ok(n >= 45 && n <= 49 && sys_rst === 1'b1, "ignored port taken");
        repeat (8) @(negedge clk);
        u_iwd_host.io_write(FACTOR_REG_OFF_ALT, 8'hc0);
        wait_act(400, n);
        ok(n >= 9 && n <= 13 && irq === 1'b1, "alternate port");
        u_iwd_host.io_write(FACTOR_REG_OFF_ALT + 10'h001, FACTOR_OFF);
        wait_act(200, n);
        ok(n == 200 && !(sys_rst | irq), "decode or disable");
        print_verdict();
    end
endmodule
